// file: hw/lp_dac1_pkg.sv
// Constants shared by the low power DAC channel 1 register bank
`default_nettype none
package lp_dac1_pkg;
   // ----------------------------------------
   // Register byte addresses
   // ----------------------------------------
   localparam logic [31:0] OUTPUT_CODES_ADDR = 32'h400c212c;
   localparam logic [31:0] SWITCH_CTRL_ADDR = 32'h400c2130;
   localparam logic [31:0] CONTROL_ADDR = 32'h400c2134;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [17:0] OUTPUT_CODES_RESET = 18'h00000;
   localparam logic [5:0] SWITCH_CTRL_RESET = 6'h00;
   localparam logic [6:0] CONTROL_RESET = 7'h02;
   // ----------------------------------------
   // Field layout
   // ----------------------------------------
   localparam int COARSE_MSB = 17;
   localparam int COARSE_LSB = 12;
   localparam int FINE_MSB = 11;
   localparam int FINE_LSB = 0;
   localparam int OVERRIDE_BIT = 5;
   localparam int SWITCH_MSB = 4;
   localparam int SOURCE_BIT = 6;
   localparam int PRESET_BIT = 5;
   localparam int ZERO_ROUTE_BIT = 4;
   localparam int BIAS_ROUTE_BIT = 3;
   localparam int REFERENCE_BIT = 2;
   localparam int POWER_DOWN_BIT = 1;
   localparam int WRITE_ENABLE_BIT = 0;
   // ----------------------------------------
   // Switch presets, bit 4 down to 0
   // ----------------------------------------
   localparam logic [4:0] NORMAL_PRESET = 5'h0a;
   localparam logic [4:0] DIAG_PRESET = 5'h15;
   // ----------------------------------------
   // Analog transfer, for reference only
   // ----------------------------------------
   localparam int COARSE_ZERO_MV = 200;
   localparam int COARSE_FULL_MV = 2366;
   localparam int COARSE_STEP_UV = 34375;
   localparam int FINE_ZERO_MV = 200;
   localparam int FINE_FULL_MV = 2400;
   localparam int FINE_STEP_UV = 537;
endpackage
`default_nettype wire

// file: hw/dac1_switch_select.sv
// Selects the output switch pattern for the DAC channel
`timescale 1ns/10ps
`default_nettype none
module dac1_switch_select (
   input wire logic overrideOn,
   input wire logic presetSelect,
   input wire logic powerDown,
   input wire logic [4:0] manualSwitches,
   output logic [4:0] switchPattern
);
   always_comb begin
      if (powerDown) begin
         switchPattern = 5'h00;
      end else if (overrideOn) begin
         switchPattern = manualSwitches;
      end else if (presetSelect) begin
         switchPattern = lp_dac1_pkg::DIAG_PRESET;
      end else begin
         switchPattern = lp_dac1_pkg::NORMAL_PRESET;
      end
   end
endmodule
`default_nettype wire

// file: hw/lp_dac_channel1_regs.sv
// Register bank and output drive for low power DAC channel 1
`timescale 1ns/10ps
`default_nettype none
module lp_dac_channel1_regs (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [31:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   input wire logic [5:0] wgenCoarse,
   input wire logic [11:0] wgenFine,
   output logic [5:0] coarseCode,
   output logic [11:0] fineCode,
   output logic biasToAmpSwitch,
   output logic biasToFilterSwitch,
   output logic zeroRef0ToTiaSwitch,
   output logic zeroRefToFilterSwitch,
   output logic zeroRefToHsTiaSwitch,
   output logic zeroNodeRoute,
   output logic biasNodeRoute,
   output logic referenceSelect,
   output logic channelPowerDown
);
   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   logic hitCodes;
   logic hitSwitch;
   logic hitControl;
   assign hitCodes = regAddr == lp_dac1_pkg::OUTPUT_CODES_ADDR;
   assign hitSwitch = regAddr == lp_dac1_pkg::SWITCH_CTRL_ADDR;
   assign hitControl = regAddr == lp_dac1_pkg::CONTROL_ADDR;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Only implemented bits are stored, so reserved bits cannot hold writes
   logic [17:0] codes_q;
   logic [5:0] switchCtrl_q;
   logic [6:0] control_q;
   logic codeWriteEnable;
   assign codeWriteEnable = control_q[lp_dac1_pkg::WRITE_ENABLE_BIT];

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         control_q <= lp_dac1_pkg::CONTROL_RESET;
      end else if (regWrite && hitControl) begin
         control_q <= regWdata[6:0];
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         switchCtrl_q <= lp_dac1_pkg::SWITCH_CTRL_RESET;
      end else if (regWrite && hitSwitch) begin
         switchCtrl_q <= regWdata[5:0];
      end
   end

   // Held at zero while writes are locked; clearing the enable also wipes it
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         codes_q <= lp_dac1_pkg::OUTPUT_CODES_RESET;
      end else if (!codeWriteEnable) begin
         codes_q <= lp_dac1_pkg::OUTPUT_CODES_RESET;
      end else if (regWrite && hitCodes) begin
         codes_q <= regWdata[17:0];
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   // Data stands for one cycle only; unmapped addresses return zero
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         regRdata <= 32'h00000000;
      end else if (regRead) begin
         if (hitCodes) begin
            regRdata <= {14'h0000, codes_q};
         end else if (hitSwitch) begin
            regRdata <= {26'h0000000, switchCtrl_q};
         end else if (hitControl) begin
            regRdata <= {25'h0000000, control_q};
         end else begin
            regRdata <= 32'h00000000;
         end
      end else begin
         regRdata <= 32'h00000000;
      end
   end

   // ----------------------------------------
   // Code source
   // ----------------------------------------
   // Codes are registered so the analog core sees glitch-free steps;
   // the voltage scale itself is set by the analog core
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         coarseCode <= 6'h00;
         fineCode <= 12'h000;
      end else if (control_q[lp_dac1_pkg::SOURCE_BIT]) begin
         coarseCode <= wgenCoarse;
         fineCode <= wgenFine;
      end else begin
         coarseCode <= codes_q[lp_dac1_pkg::COARSE_MSB:lp_dac1_pkg::COARSE_LSB];
         fineCode <= codes_q[lp_dac1_pkg::FINE_MSB:lp_dac1_pkg::FINE_LSB];
      end
   end

   // ----------------------------------------
   // Output switches
   // ----------------------------------------
   logic [4:0] switchPattern;
   logic [4:0] switches_q;

   dac1_switch_select switchSelect (
      .overrideOn(switchCtrl_q[lp_dac1_pkg::OVERRIDE_BIT]),
      .presetSelect(control_q[lp_dac1_pkg::PRESET_BIT]),
      .powerDown(control_q[lp_dac1_pkg::POWER_DOWN_BIT]),
      .manualSwitches(switchCtrl_q[lp_dac1_pkg::SWITCH_MSB:0]),
      .switchPattern(switchPattern)
   );

   // Registered so a register write never glitches a switch
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         switches_q <= 5'h00;
      end else begin
         switches_q <= switchPattern;
      end
   end

   assign biasToAmpSwitch = switches_q[4];
   assign biasToFilterSwitch = switches_q[3];
   assign zeroRef0ToTiaSwitch = switches_q[2];
   assign zeroRefToFilterSwitch = switches_q[1];
   assign zeroRefToHsTiaSwitch = switches_q[0];

   // ----------------------------------------
   // Routing, reference and power
   // ----------------------------------------
   // Unequal route bits are passed on as written; software must keep them equal
   assign zeroNodeRoute = control_q[lp_dac1_pkg::ZERO_ROUTE_BIT];
   assign biasNodeRoute = control_q[lp_dac1_pkg::BIAS_ROUTE_BIT];
   assign referenceSelect = control_q[lp_dac1_pkg::REFERENCE_BIT];
   assign channelPowerDown = control_q[lp_dac1_pkg::POWER_DOWN_BIT];

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   logic [4:0] switchesView;
   assign switchesView = {biasToAmpSwitch, biasToFilterSwitch, zeroRef0ToTiaSwitch,
                          zeroRefToFilterSwitch, zeroRefToHsTiaSwitch};

   codes_readback_a: assert property (
      regWrite && hitCodes && codeWriteEnable ##1 regRead && hitCodes
      |=> regRdata == {14'h0000, $past(regWdata[17:0], 2)})
      else $error("code register readback mismatch");

   codes_locked_a: assert property (
      !codeWriteEnable ##1 regRead && hitCodes |=> regRdata == 32'h00000000)
      else $error("locked code register did not read zero");

   control_reserved_a: assert property (
      regWrite && hitControl ##1 regRead && hitControl
      |=> regRdata[31:7] == 25'h0000000 && regRdata[6:0] == $past(regWdata[6:0], 2))
      else $error("control readback wrong or reserved bits set");

   switch_reserved_a: assert property (
      regRead && hitSwitch |=> regRdata[31:6] == 26'h0000000)
      else $error("switch register reserved bits not zero");

   power_down_a: assert property (
      channelPowerDown [*2] |-> switchesView == 5'h00)
      else $error("switches closed while powered down");

   override_drive_a: assert property (
      !channelPowerDown && switchCtrl_q[5] |=> switchesView == $past(switchCtrl_q[4:0]))
      else $error("override did not drive switches");

   preset_normal_a: assert property (
      !channelPowerDown && !switchCtrl_q[5] && !control_q[5]
      |=> switchesView == lp_dac1_pkg::NORMAL_PRESET)
      else $error("normal preset not applied");

   preset_diag_a: assert property (
      !channelPowerDown && !switchCtrl_q[5] && control_q[5]
      |=> switchesView == lp_dac1_pkg::DIAG_PRESET)
      else $error("diagnostic preset not applied");

   source_wgen_a: assert property (
      control_q[6] |=> coarseCode == $past(wgenCoarse) && fineCode == $past(wgenFine))
      else $error("waveform generator codes not passed");

   source_direct_a: assert property (
      !control_q[6] |=> {coarseCode, fineCode} == $past(codes_q))
      else $error("register codes not passed");

   route_write_a: assert property (
      regWrite && hitControl |=> zeroNodeRoute == $past(regWdata[4])
      && biasNodeRoute == $past(regWdata[3]) && referenceSelect == $past(regWdata[2]))
      else $error("route or reference not taken from write");

   unmapped_read_a: assert property (
      regRead && !hitCodes && !hitSwitch && !hitControl |=> regRdata == 32'h00000000)
      else $error("unmapped read returned data");

   // ----------------------------------------
   // Storage and read port checks
   // ----------------------------------------
   // Checked on the first edge after release, before any request can land
   reset_values_a: assert property (
      $rose(resetn) |-> control_q == lp_dac1_pkg::CONTROL_RESET
      && switchCtrl_q == lp_dac1_pkg::SWITCH_CTRL_RESET
      && codes_q == lp_dac1_pkg::OUTPUT_CODES_RESET)
      else $error("register not at reset value after release");

   reset_outputs_a: assert property (
      $rose(resetn) |-> channelPowerDown && switchesView == 5'h00
      && regRdata == 32'h00000000)
      else $error("outputs not idle after release");

   read_idle_a: assert property (
      !regRead |=> regRdata == 32'h00000000)
      else $error("read data stood without a read");

   codes_reserved_a: assert property (
      regRead && hitCodes |=> regRdata[31:18] == 14'h0000)
      else $error("code register reserved bits not zero");

   codes_write_a: assert property (
      regWrite && hitCodes && codeWriteEnable |=> codes_q == $past(regWdata[17:0]))
      else $error("enabled code write did not land");

   codes_hold_a: assert property (
      codeWriteEnable && !(regWrite && hitCodes) |=> $stable(codes_q))
      else $error("code register changed without a write");

   codes_ignored_a: assert property (
      !codeWriteEnable |=> codes_q == 18'h00000)
      else $error("code register held data while locked");

   codes_drive_zero_a: assert property (
      !codeWriteEnable && !control_q[lp_dac1_pkg::SOURCE_BIT]
      ##1 !control_q[lp_dac1_pkg::SOURCE_BIT] |=> coarseCode == 6'h00 && fineCode == 12'h000)
      else $error("locked codes not driven zero");

   switch_readback_a: assert property (
      regWrite && hitSwitch ##1 regRead && hitSwitch
      |=> regRdata == {26'h0000000, $past(regWdata[5:0], 2)})
      else $error("switch register readback mismatch");

   switch_hold_a: assert property (
      !(regWrite && hitSwitch) |=> $stable(switchCtrl_q))
      else $error("switch register changed without a write");

   unmapped_write_a: assert property (
      regWrite && !hitCodes && !hitSwitch && !hitControl
      |=> $stable(control_q) && $stable(switchCtrl_q))
      else $error("unmapped write changed a register");

   control_hold_a: assert property (
      !(regWrite && hitControl)
      |=> $stable({zeroNodeRoute, biasNodeRoute, referenceSelect, channelPowerDown}))
      else $error("control outputs changed without a write");

   bias_route_a: assert property (
      regWrite && hitControl
      |=> biasNodeRoute == $past(regWdata[lp_dac1_pkg::BIAS_ROUTE_BIT]))
      else $error("bias route not taken from write");

   reference_a: assert property (
      regWrite && hitControl
      |=> referenceSelect == $past(regWdata[lp_dac1_pkg::REFERENCE_BIT]))
      else $error("reference select not taken from write");

   power_down_write_a: assert property (
      regWrite && hitControl && regWdata[lp_dac1_pkg::POWER_DOWN_BIT]
      |-> ##2 switchesView == 5'h00)
      else $error("power down did not open switches");

   wgen_unlocked_a: assert property (
      control_q[lp_dac1_pkg::SOURCE_BIT] && !codeWriteEnable
      |=> fineCode == $past(wgenFine))
      else $error("waveform codes blocked by write lock");

   // ----------------------------------------
   // Per-switch override checks
   // ----------------------------------------
   amp_switch_a: assert property (
      !channelPowerDown && switchCtrl_q[lp_dac1_pkg::OVERRIDE_BIT]
      |=> biasToAmpSwitch == $past(switchCtrl_q[4]))
      else $error("amplifier switch not driven from bit 4");

   bias_filter_a: assert property (
      !channelPowerDown && switchCtrl_q[lp_dac1_pkg::OVERRIDE_BIT]
      |=> biasToFilterSwitch == $past(switchCtrl_q[3]))
      else $error("bias filter switch not driven from bit 3");

   tia_switch_a: assert property (
      !channelPowerDown && switchCtrl_q[lp_dac1_pkg::OVERRIDE_BIT]
      |=> zeroRef0ToTiaSwitch == $past(switchCtrl_q[2]))
      else $error("amplifier zero switch not driven from bit 2");

   zero_filter_a: assert property (
      !channelPowerDown && switchCtrl_q[lp_dac1_pkg::OVERRIDE_BIT]
      |=> zeroRefToFilterSwitch == $past(switchCtrl_q[1]))
      else $error("zero filter switch not driven from bit 1");

   hs_tia_a: assert property (
      !channelPowerDown && switchCtrl_q[lp_dac1_pkg::OVERRIDE_BIT]
      |=> zeroRefToHsTiaSwitch == $past(switchCtrl_q[0]))
      else $error("high speed switch not driven from bit 0");

   power_up_c: cover property (regWrite && hitControl && !regWdata[1]);
   override_c: cover property (switchCtrl_q[5] && !channelPowerDown ##1 switchesView != 5'h00);
   wgen_c: cover property (control_q[6] ##1 fineCode != 12'h000);
   code_write_c: cover property (regWrite && hitCodes && codeWriteEnable);
   lock_clear_c: cover property (codeWriteEnable ##1 !codeWriteEnable);
endmodule
`default_nettype wire

// file: tb/dac1_core_model.sv
// Behavioural model of the analog DAC core fed by channel 1
`timescale 1ns/10ps
`default_nettype none
module dac1_core_model (
   input wire logic [5:0] coarseCode,
   input wire logic [11:0] fineCode,
   input wire logic zeroNodeRoute,
   input wire logic biasNodeRoute,
   output var logic [31:0] zeroUv,
   output var logic [31:0] biasUv
);
   // Four-state arithmetic so an unknown code shows up as an unknown voltage
   logic [31:0] coarseUv;
   logic [31:0] fineUv;
   // ----------------------------------------
   // Node voltages in microvolts
   // ----------------------------------------
   always_comb begin
      coarseUv = 32'h00030d40 + 32'h00008647 * {26'h0000000, coarseCode};
      fineUv = 32'h00030d40 + 32'h00000219 * {20'h00000, fineCode};
      zeroUv = zeroNodeRoute ? fineUv : coarseUv;
      biasUv = biasNodeRoute ? coarseUv : fineUv;
   end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the DAC channel 1 register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam logic [31:0] A_COD = lp_dac1_pkg::OUTPUT_CODES_ADDR;
   localparam logic [31:0] A_SW = lp_dac1_pkg::SWITCH_CTRL_ADDR;
   localparam logic [31:0] A_CTL = lp_dac1_pkg::CONTROL_ADDR;
   logic mclk, resetn, regWrite, regRead;
   logic [31:0] regAddr, regWdata, regRdata;
   logic [5:0] wgenCoarse, coarseCode;
   logic [11:0] wgenFine, fineCode;
   wire logic [4:0] sw;
   logic zeroNodeRoute, biasNodeRoute, referenceSelect, channelPowerDown;
   int errors = 0;
   int n_tests = 0;
   logic [31:0] zeroUv, biasUv;
   lp_dac_channel1_regs dut (.mclk(mclk), .resetn(resetn), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .regRdata(regRdata), .wgenCoarse(wgenCoarse), .wgenFine(wgenFine),
      .coarseCode(coarseCode), .fineCode(fineCode), .biasToAmpSwitch(sw[4]),
      .biasToFilterSwitch(sw[3]), .zeroRef0ToTiaSwitch(sw[2]),
      .zeroRefToFilterSwitch(sw[1]), .zeroRefToHsTiaSwitch(sw[0]),
      .zeroNodeRoute(zeroNodeRoute), .biasNodeRoute(biasNodeRoute),
      .referenceSelect(referenceSelect), .channelPowerDown(channelPowerDown));
   dac1_core_model core (.coarseCode(coarseCode), .fineCode(fineCode),
      .zeroNodeRoute(zeroNodeRoute), .biasNodeRoute(biasNodeRoute),
      .zeroUv(zeroUv), .biasUv(biasUv));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Write, then let register and output stages settle
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge mclk);
      regWrite <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input string what);
      @(posedge mclk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRead <= 1'b0;
      #1;
      chk(regRdata, exp, what);
   endtask
   task automatic end_of_test;
      $display("Counts: %0d checks, %0d mismatches", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_reset;
      chk({31'h0, channelPowerDown}, 32'h1, "power down at reset");
      chk({27'h0, sw}, 32'h0, "switches at reset");
      chk({14'h0, coarseCode, fineCode}, 32'h0, "codes at reset");
      rdchk(A_CTL, 32'h2, "control reset");
      @(posedge mclk);
      #1;
      chk(regRdata, 32'h0, "read data one cycle");
      rdchk(A_COD, 32'h0, "codes reset");
      rdchk(A_SW, 32'h0, "switch reset");
      $display("test_reset done");
   endtask
   task automatic test_codes;
      wr(A_COD, 32'h3f123);
      rdchk(A_COD, 32'h0, "write while disabled");
      wr(A_CTL, 32'h1);
      wr(A_COD, 32'hffffffff);
      rdchk(A_COD, 32'h3ffff, "codes readback");
      chk({14'h0, coarseCode, fineCode}, 32'h3ffff, "codes out");
      chk(zeroUv, 2365625, "zero node full");
      chk(biasUv, 2399015, "bias node full");
      wr(A_COD, 32'h0);
      chk(zeroUv, 200000, "zero node low");
      chk(biasUv, 200000, "bias node low");
      wr(A_COD, 32'h15abc);
      wr(A_CTL, 32'h0);
      rdchk(A_COD, 32'h0, "disable clears");
      chk({14'h0, coarseCode, fineCode}, 32'h0, "codes driven zero");
      $display("test_codes done");
   endtask
   task automatic test_switches;
      wr(A_CTL, 32'h1);
      chk(sw, lp_dac1_pkg::NORMAL_PRESET, "normal preset");
      wr(A_CTL, 32'h21);
      chk(sw, lp_dac1_pkg::DIAG_PRESET, "diag preset");
      wr(A_SW, 32'hffffffc0);
      rdchk(A_SW, 32'h0, "switch reserved");
      chk(sw, lp_dac1_pkg::DIAG_PRESET, "preset kept");
      for (int i = 0; i < 5; i++) begin
         wr(A_SW, 32'h20 | (32'h1 << i));
         chk(sw, 5'h1 << i, "manual switch");
      end
      wr(A_CTL, 32'h23);
      chk(sw, 5'h0, "power down opens");
      rdchk(A_SW, 32'h30, "switch readback");
      $display("test_switches done");
   endtask
   task automatic test_source;
      wr(A_CTL, 32'h5c);
      chk({26'h0, coarseCode}, 32'h15, "wgen coarse");
      chk({20'h0, fineCode}, 32'habc, "wgen fine");
      chk({zeroNodeRoute, biasNodeRoute, referenceSelect, channelPowerDown},
         4'he, "routes set");
      chk(zeroUv, 1675676, "zero from fine");
      chk(biasUv, 921875, "bias from coarse");
      @(posedge mclk);
      wgenCoarse <= 6'h2a;
      wgenFine <= 12'h543;
      repeat (2) @(posedge mclk);
      #1;
      chk({14'h0, coarseCode, fineCode}, 32'h2a543, "wgen followed while locked");
      rdchk(A_CTL, 32'h5c, "control readback");
      wr(A_CTL, 32'hffffff80);
      rdchk(A_CTL, 32'h0, "control reserved");
      chk({zeroNodeRoute, biasNodeRoute, referenceSelect, channelPowerDown},
         4'h0, "routes clear");
      chk({14'h0, coarseCode, fineCode}, 32'h0, "direct codes back");
      wr(32'h400c2138, 32'hffffffff);
      rdchk(32'h400c2138, 32'h0, "unmapped read");
      rdchk(A_CTL, 32'h0, "unmapped write ignored");
      $display("test_source done");
   endtask
   task automatic test_midreset;
      wr(A_CTL, 32'h7d);
      wr(A_SW, 32'h3f);
      wr(A_COD, 32'h2a555);
      rdchk(A_COD, 32'h2a555, "codes before reset");
      @(posedge mclk);
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      #1;
      chk({zeroNodeRoute, biasNodeRoute, referenceSelect, channelPowerDown},
         4'h1, "routes after reset");
      chk({27'h0, sw}, 32'h0, "switches after reset");
      chk({14'h0, coarseCode, fineCode}, 32'h0, "codes out after reset");
      rdchk(A_CTL, 32'h2, "control after reset");
      rdchk(A_SW, 32'h0, "switch after reset");
      rdchk(A_COD, 32'h0, "codes after reset");
      $display("test_midreset done");
   endtask
   // ----------------------------------------
   // Clock and main sequence
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      resetn = 1'b0;
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 32'h0;
      regWdata = 32'h0;
      wgenCoarse = 6'h15;
      wgenFine = 12'habc;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      #1;
      test_reset();
      test_codes();
      test_switches();
      test_source();
      test_midreset();
      end_of_test();
   end
endmodule
`default_nettype wire
